// File: include/lps_pkg.sv
// Constants, types and register map of the LCD pin function select block.
package lps_pkg;
   localparam int NUM_PINS = 20;
   localparam int NUM_LINES = 6;

   // Byte offsets within the slave's window
   localparam logic [3:0] OFS_ROLE = 4'h0;
   localparam logic [3:0] OFS_SEG_LOW = 4'h4;
   localparam logic [3:0] OFS_SEG_HIGH = 4'h8;
   localparam logic [3:0] OFS_CTRL = 4'hc;

   localparam logic [7:0] RST_ROLE = 8'h00;
   localparam logic [7:0] RST_SEG_LOW = 8'h00;
   localparam logic [5:0] RST_SEG_HIGH = 6'h00;
   localparam logic [5:0] RST_CTRL = 6'h00;

   localparam int SEG_HIGH_W = 6;
   localparam int CTRL_W = 6;
   localparam int ROLE_LINE4_SEL = 6;
   localparam int ROLE_LINE5_SEL = 7;
   localparam int CTRL_MASTER_EN = 0;
   localparam int CTRL_FRAME = 1;
   localparam int CTRL_LINE0_SEL = 2;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      LPS_LVL_VSS = 2'h0,
      LPS_LVL_BIAS_LOW = 2'h1,
      LPS_LVL_BIAS_HIGH = 2'h2,
      LPS_LVL_VDD = 2'h3
   } lps_level_t;

   typedef struct packed {
      logic master_en;
      logic frame;
   } lps_lcd_ctl_t;
endpackage

// File: logic/lps_pin_cell.sv
// One shared pin: LCD drive level versus port/other-function pass-through.
`timescale 1ns/10ps
module lps_pin_cell (
   input wire logic aclk,                  // System clock
   input wire logic aresetn,               // Synchronous reset, active low
   input wire logic sel,                   // Pin handed to LCD drive
   input wire logic seg_role,              // 1 segment line, 0 common line
   input wire lps_pkg::lps_lcd_ctl_t ctl,  // Master enable and frame
   input wire logic port_bit,              // Pin-shared port data bit
   input wire logic other_out,             // Other-function output level
   input wire logic other_oe_n,            // Other-function output enable
   output lps_pkg::lps_level_t level,      // Analog drive level request
   output logic lcd_sel,                   // Pin owned by LCD driver
   output logic pad_out,                   // Digital pad output
   output logic pad_oe_n                   // Digital pad enable, low drives
);
   lps_pkg::lps_level_t next_level;
   logic next_lcd_sel;
   logic next_pad_out;
   logic next_pad_oe_n;
   logic up;

   always_comb begin
      up = seg_role ^ ~ctl.frame;
      next_lcd_sel = sel;
      next_level = lps_pkg::LPS_LVL_VSS;
      next_pad_out = other_out;
      next_pad_oe_n = other_oe_n;
      if (sel) begin
         // Digital driver is released so it cannot fight the analog level
         next_pad_out = 1'b0;
         next_pad_oe_n = 1'b1;
         if (!ctl.master_en) begin
            next_level = lps_pkg::LPS_LVL_VSS;
         end else if (up) begin
            next_level = port_bit ? lps_pkg::LPS_LVL_VDD : lps_pkg::LPS_LVL_BIAS_LOW;
         end else begin
            next_level = port_bit ? lps_pkg::LPS_LVL_VSS : lps_pkg::LPS_LVL_BIAS_HIGH;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         level <= lps_pkg::LPS_LVL_VSS;
         lcd_sel <= 1'b0;
         pad_out <= 1'b0;
         pad_oe_n <= 1'b1;
      end else begin
         level <= next_level;
         lcd_sel <= next_lcd_sel;
         pad_out <= next_pad_out;
         pad_oe_n <= next_pad_oe_n;
      end
   end
endmodule

// File: logic/lps_pin_select.sv
// AXI4-Lite register bank and pin function selection for the software LCD driver.
`timescale 1ns/10ps
module lps_pin_select #(
   parameter int ADDR_W = 8
) (
   input wire logic aclk,                                     // System clock, 25 MHz
   input wire logic aresetn,                                  // Synchronous reset, active low
   input wire logic [ADDR_W-1:0] awaddr,                      // Write address
   input wire logic awvalid,                                  // Write address valid
   output logic awready,                                      // Write address ready
   input wire logic [31:0] wdata,                             // Write data
   input wire logic [3:0] wstrb,                              // Write byte strobes
   input wire logic wvalid,                                   // Write data valid
   output logic wready,                                       // Write data ready
   output logic [1:0] bresp,                                  // Write response
   output logic bvalid,                                       // Write response valid
   input wire logic bready,                                   // Write response ready
   input wire logic [ADDR_W-1:0] araddr,                      // Read address
   input wire logic arvalid,                                  // Read address valid
   output logic arready,                                      // Read address ready
   output logic [31:0] rdata,                                 // Read data
   output logic [1:0] rresp,                                  // Read response
   output logic rvalid,                                       // Read data valid
   input wire logic rready,                                   // Read data ready
   input wire logic [lps_pkg::NUM_PINS-1:0] port_data,        // Port data bits, same clock
   input wire logic [lps_pkg::NUM_PINS-1:0] other_out,        // Other-function levels
   input wire logic [lps_pkg::NUM_PINS-1:0] other_oe_n,       // Other-function enables
   output lps_pkg::lps_level_t [lps_pkg::NUM_PINS-1:0] lcd_level, // Drive level per pin
   output logic [lps_pkg::NUM_PINS-1:0] lcd_pin_select,       // Pin owned by LCD
   output logic [lps_pkg::NUM_PINS-1:0] pad_out,              // Digital pad output
   output logic [lps_pkg::NUM_PINS-1:0] pad_oe_n              // Digital pad enable, low drives
);
   if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr
      $error("ADDR_W must lie between 4 and 32");
   end

   // One-hot register hit: {ctrl, seg_high, seg_low, role}; zero when unmapped
   function automatic logic [3:0] reg_hit(input logic [ADDR_W-1:0] a);
      logic [3:0] h;
      h = 4'h0;
      if (a[ADDR_W-1:4] == '0) begin
         h[0] = (a[3:0] == lps_pkg::OFS_ROLE);
         h[1] = (a[3:0] == lps_pkg::OFS_SEG_LOW);
         h[2] = (a[3:0] == lps_pkg::OFS_SEG_HIGH);
         h[3] = (a[3:0] == lps_pkg::OFS_CTRL);
      end
      return h;
   endfunction

   // Register file
   logic [7:0] role;
   logic [7:0] seg_low;
   logic [lps_pkg::SEG_HIGH_W-1:0] seg_high;
   logic [lps_pkg::CTRL_W-1:0] ctrl;
   logic [7:0] next_role;
   logic [7:0] next_seg_low;
   logic [lps_pkg::SEG_HIGH_W-1:0] next_seg_high;
   logic [lps_pkg::CTRL_W-1:0] next_ctrl;

   // Write channel state
   logic aw_held, w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [7:0] w_byte;
   logic w_lane0;
   logic next_aw_held, next_w_held, next_w_lane0;
   logic [ADDR_W-1:0] next_aw_addr;
   logic [7:0] next_w_byte;
   logic next_awready, next_wready, next_bvalid;
   logic [1:0] next_bresp;
   logic wr_commit;
   logic [3:0] wr_hit;

   // Read channel state
   logic next_arready, next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp;
   logic [3:0] rd_hit;

   always_comb begin
      wr_commit = aw_held & w_held & ~bvalid;
      wr_hit = reg_hit(aw_addr);
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_aw_addr = aw_addr;
      next_w_byte = w_byte;
      next_w_lane0 = w_lane0;
      next_bvalid = bvalid;
      next_bresp = bresp;
      if (awvalid && awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = awaddr;
      end
      if (wvalid && wready) begin
         next_w_held = 1'b1;
         next_w_byte = wdata[7:0];
         next_w_lane0 = wstrb[0];
      end
      if (bvalid && bready) begin
         next_bvalid = 1'b0;
      end
      if (wr_commit) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = (wr_hit == 4'h0) ? lps_pkg::RESP_SLVERR : lps_pkg::RESP_OKAY;
      end
      // Only one write in flight: no new address or data until the response is taken
      next_awready = ~next_aw_held & ~next_bvalid;
      next_wready = ~next_w_held & ~next_bvalid;
   end

   always_comb begin
      next_role = role;
      next_seg_low = seg_low;
      next_seg_high = seg_high;
      next_ctrl = ctrl;
      // Registers fit in one byte (seg_high and ctrl are 6 bits), so only lane 0 can change them
      if (wr_commit && w_lane0) begin
         if (wr_hit[0]) next_role = w_byte;
         if (wr_hit[1]) next_seg_low = w_byte;
         if (wr_hit[2]) next_seg_high = w_byte[lps_pkg::SEG_HIGH_W-1:0];
         if (wr_hit[3]) next_ctrl = w_byte[lps_pkg::CTRL_W-1:0];
      end
   end

   always_comb begin
      rd_hit = reg_hit(araddr);
      next_arready = arready;
      next_rvalid = rvalid;
      next_rdata = rdata;
      next_rresp = rresp;
      if (rvalid && rready) begin
         next_rvalid = 1'b0;
      end
      if (arvalid && arready) begin
         next_rvalid = 1'b1;
         next_rresp = (rd_hit == 4'h0) ? lps_pkg::RESP_SLVERR : lps_pkg::RESP_OKAY;
         next_rdata = 32'h0000_0000;
         unique case (1'b1)
            rd_hit[0]: next_rdata[7:0] = role;
            rd_hit[1]: next_rdata[7:0] = seg_low;
            rd_hit[2]: next_rdata[lps_pkg::SEG_HIGH_W-1:0] = seg_high;
            rd_hit[3]: next_rdata[lps_pkg::CTRL_W-1:0] = ctrl;
            default: next_rdata = 32'h0000_0000;
         endcase
      end
      next_arready = ~next_rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         role <= lps_pkg::RST_ROLE;
         seg_low <= lps_pkg::RST_SEG_LOW;
         seg_high <= lps_pkg::RST_SEG_HIGH;
         ctrl <= lps_pkg::RST_CTRL;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_byte <= 8'h00;
         w_lane0 <= 1'b0;
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= 2'h0;
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= 2'h0;
      end else begin
         role <= next_role;
         seg_low <= next_seg_low;
         seg_high <= next_seg_high;
         ctrl <= next_ctrl;
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         aw_addr <= next_aw_addr;
         w_byte <= next_w_byte;
         w_lane0 <= next_w_lane0;
         awready <= next_awready;
         wready <= next_wready;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         arready <= next_arready;
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
      end
   end

   // Pin map: lines 0..3 from control, 4..5 from role bits 6..7, then segments
   logic [lps_pkg::NUM_PINS-1:0] sel_vec;
   logic [lps_pkg::NUM_PINS-1:0] seg_role_vec;
   lps_pkg::lps_lcd_ctl_t lcd_ctl;

   always_comb begin
      sel_vec = {seg_high, seg_low, role[lps_pkg::ROLE_LINE5_SEL], role[lps_pkg::ROLE_LINE4_SEL],
                 ctrl[lps_pkg::CTRL_LINE0_SEL +: 4]};
      seg_role_vec = {{(lps_pkg::NUM_PINS - lps_pkg::NUM_LINES){1'b1}},
                      role[lps_pkg::NUM_LINES-1:0]};
      lcd_ctl.master_en = ctrl[lps_pkg::CTRL_MASTER_EN];
      lcd_ctl.frame = ctrl[lps_pkg::CTRL_FRAME];
   end

   for (genvar i = 0; i < lps_pkg::NUM_PINS; i++) begin : g_pin
      lps_pin_cell u_cell (
         .aclk(aclk),
         .aresetn(aresetn),
         .sel(sel_vec[i]),
         .seg_role(seg_role_vec[i]),
         .ctl(lcd_ctl),
         .port_bit(port_data[i]),
         .other_out(other_out[i]),
         .other_oe_n(other_oe_n[i]),
         .level(lcd_level[i]),
         .lcd_sel(lcd_pin_select[i]),
         .pad_out(pad_out[i]),
         .pad_oe_n(pad_oe_n[i])
      );
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_line45_handover: assert property (lcd_pin_select[5:4] == $past(role[7:6]))
      else $error("line 4/5 ownership does not follow role bits 7..6");
   chk_common_role_level: assert property ($past(ctrl[0] && !ctrl[1] && ctrl[3] && !role[1] && port_data[1])
      |-> lcd_level[1] == lps_pkg::LPS_LVL_VDD)
      else $error("common line in frame 0 with data 1 not at supply");
   chk_seg_low_map: assert property (lcd_pin_select[13:6] == $past(seg_low))
      else $error("segment pins 6..13 do not follow low segment register");
   chk_seg_high_map: assert property (lcd_pin_select[19:14] == $past(seg_high))
      else $error("segment pins 14..19 do not follow high segment register");
   chk_reserved_read: assert property ($past(arvalid && arready && rd_hit[2]) |-> rdata[31:6] == 26'h0)
      else $error("unimplemented high segment bits read nonzero");
   chk_reset_clear: assert property (disable iff (1'b0) !aresetn |=>
      role == 8'h00 && seg_low == 8'h00 && seg_high == 6'h00 && lcd_pin_select == '0)
      else $error("select bits not clear after reset");
   chk_write_readback: assert property (wr_commit && w_lane0 && wr_hit[1] |=> seg_low == $past(w_byte))
      else $error("low segment register does not hold the written value");
   chk_master_off_vss: assert property ($past(!ctrl[0]) |-> lcd_level == '0)
      else $error("LCD output not at ground with master enable off");
   chk_frame_level: assert property ($past(ctrl[0] && ctrl[1] && seg_high[0] && !port_data[14])
      |-> lcd_level[14] == lps_pkg::LPS_LVL_BIAS_LOW)
      else $error("segment frame 1 data 0 not at low bias");
   // The edge that leaves reset still shows reset pad values, so it is not judged
   chk_other_passthru: assert property ($past(aresetn && !sel_vec[0]) |->
      pad_out[0] == $past(other_out[0]) && pad_oe_n[0] == $past(other_oe_n[0]))
      else $error("unselected pin not driven by port logic");

   cov_write_done: cover property (bvalid && bready && bresp == lps_pkg::RESP_OKAY);
   cov_read_done: cover property (rvalid && rready && rdata[7:0] != 8'h00);
   cov_bias_drive: cover property (lcd_level[19] == lps_pkg::LPS_LVL_BIAS_HIGH);
   cov_unmapped: cover property (rvalid && rresp == lps_pkg::RESP_SLVERR);
endmodule

// File: testbench/lps_port_model.sv
// Port-side partner: random port data and other-function pin drive.
`timescale 1ns/10ps
module lps_port_model #(
   parameter int SEED = 32'h1d5
) (
   input wire logic aclk,           // System clock
   output logic [19:0] port_data,   // Port data bit of each pin
   output logic [19:0] other_out,   // Other-function level
   output logic [19:0] other_oe_n   // Other-function enable, low drives
);
   integer s = SEED;
   logic [59:0] v = 60'h0;

   // New values every cycle so a stale sample can never pass for a fresh one
   assign {port_data, other_out, other_oe_n} = v;
   always @(posedge aclk) begin
      v <= 60'({$random(s), $random(s)});
   end
endmodule

// File: testbench/testbench.sv
// Self-checking bench for the LCD pin function select block.
`timescale 1ns/10ps
module testbench;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata, d;
   logic [19:0] port_data, other_out, other_oe_n, lcd_pin_select, pad_out, pad_oe_n;
   lps_pkg::lps_level_t [19:0] lcd_level;
   int error_cnt = 0, tests_run = 0;
   integer seed = 32'hfefc;
   logic [7:0] m [4];
   logic chk_en = 1'b0;
   logic [19:0] e_sel, e_out, e_oe;
   logic [39:0] e_lvl;

   always #20 aclk = ~aclk;

   lps_pin_select #(.ADDR_W(8)) lps_pin_select_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .port_data(port_data),
      .other_out(other_out), .other_oe_n(other_oe_n), .lcd_level(lcd_level),
      .lcd_pin_select(lcd_pin_select), .pad_out(pad_out), .pad_oe_n(pad_oe_n));
   lps_port_model lps_port_model_inst (.aclk(aclk), .port_data(port_data), .other_out(other_out),
      .other_oe_n(other_oe_n));

   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic tmo(input int n);
      if (n >= 100) begin
         check("handshake timeout", 64'h1, 64'h0);
         stop_test();
      end
   endtask

   function automatic logic [1:0] lvl(input logic on, input logic x, input logic dd);
      if (!on) return lps_pkg::LPS_LVL_VSS;
      if (x) return dd ? lps_pkg::LPS_LVL_VSS : lps_pkg::LPS_LVL_BIAS_HIGH;
      return dd ? lps_pkg::LPS_LVL_VDD : lps_pkg::LPS_LVL_BIAS_LOW;
   endfunction

   task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [3:0] s);
      int n;
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= dat;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while ((aw || w) && n < 100) begin
         @(posedge aclk);
         n++;
         if (aw && awready) begin
            awvalid <= 1'b0;
            aw = 1'b0;
         end
         if (w && wready) begin
            wvalid <= 1'b0;
            w = 1'b0;
         end
      end
      while (!bvalid && n < 100) begin
         @(posedge aclk);
         n++;
      end
      r = bresp;
      bready <= 1'b0;
      tmo(n);
   endtask

   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
      end while (!arready && n < 100);
      arvalid <= 1'b0;
      while (!rvalid && n < 100) begin
         @(posedge aclk);
         n++;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      tmo(n);
   endtask

   // Pin checks pause while a write lands, since the pins update a cycle after the register
   task automatic wreg(input int k, input logic [31:0] dat);
      chk_en = 1'b0;
      wr({k[5:0], 2'b00}, dat, 4'hf);
      check("bresp", r, lps_pkg::RESP_OKAY);
      m[k] = dat[7:0] & (k > 1 ? 8'h3f : 8'hff);
      @(posedge aclk);
      chk_en = 1'b1;
   endtask

   task automatic rreg(input int k);
      rd({k[5:0], 2'b00});
      check("rdata", d, {24'h0, m[k]});
      check("rresp", r, lps_pkg::RESP_OKAY);
   endtask

   always @(posedge aclk) begin
      for (int i = 0; i < 20; i++) begin
         e_sel[i] = i < 4 ? m[3][i + 2] : i < 6 ? m[0][i + 2] : i < 14 ? m[1][i - 6] : m[2][i - 14];
         e_out[i] = e_sel[i] ? 1'b0 : other_out[i];
         e_oe[i] = e_sel[i] | other_oe_n[i];
         e_lvl[2 * i +: 2] = lvl(e_sel[i] & m[3][0], (i > 5 ? 1'b1 : m[0][i]) ^ m[3][1], port_data[i]);
      end
      #1;
      if (chk_en) begin
         check("lcd_pin_select", lcd_pin_select, e_sel);
         check("lcd_level", lcd_level, e_lvl);
         check("pad_out", pad_out, e_out);
         check("pad_oe_n", pad_oe_n, e_oe);
      end
   end

   initial begin
      m = '{default: 8'h00};
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      chk_en = 1'b1;
      for (int k = 0; k < 4; k++) rreg(k);
      // Unmapped place is refused and leaves the bank alone
      wr(8'h10, 32'hff, 4'hf);
      check("bresp unmapped", r, lps_pkg::RESP_SLVERR);
      rd(8'h10);
      check("rdata unmapped", d, 32'h0);
      check("rresp unmapped", r, lps_pkg::RESP_SLVERR);
      chk_en = 1'b0;
      wr(8'h04, 32'hff, 4'he);
      check("bresp no strobe", r, lps_pkg::RESP_OKAY);
      rreg(1);
      wreg(2, 32'hffffffff);
      rreg(2);
      wreg(1, 32'hff);
      for (int rr = 0; rr < 2; rr++) begin
         wreg(0, rr ? 32'hff : 32'hc0);
         for (int k = 0; k < 4; k++) begin
            wreg(3, 32'h3c | k);
            repeat (4) @(posedge aclk);
         end
      end
      repeat (40) begin
         int k;
         k = $random(seed) & 3;
         wreg(k, $random(seed));
         rreg(k);
      end
      chk_en = 1'b0;
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      m = '{default: 8'h00};
      repeat (2) @(posedge aclk);
      chk_en = 1'b1;
      for (int k = 0; k < 4; k++) rreg(k);
      repeat (4) @(posedge aclk);
      stop_test();
   end
endmodule
